// ==== logic/csp_pkg.sv ====
/*
  Constants, types and instruction codes for the configuration access,
  security and power-up reset block. Assumes one 200 MHz reference clock
  and a boundary-scan port whose pins arrive asynchronously.
*/
package csp_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int POR_TIME_US   = 1;     // Power-up reset time, in us
  localparam int CLK_PERIOD_PS = 5000;  // 200 MHz reference clock
  localparam int POR_CYC       = (POR_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int POR_CW        = 9;

  // ----------------------------------------------------------------
  // Widths and instruction codes
  // ----------------------------------------------------------------
  localparam int SIG_W  = 32;           // User signature width
  localparam int CFG_W  = 16;           // Configuration word width
  localparam int DR_W   = 32;           // Widest data register
  localparam int IR_W   = 4;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] OP_READ    = 4'h2;
  localparam logic [IR_W-1:0] OP_WRITE   = 4'h3;
  localparam logic [IR_W-1:0] OP_VERIFY  = 4'h4;
  localparam logic [IR_W-1:0] OP_ERASE   = 4'h5;
  localparam logic [IR_W-1:0] OP_SECURE  = 4'h6;
  localparam logic [IR_W-1:0] OP_USERSIG = 4'h8;
  localparam logic [IR_W-1:0] OP_SIGWR   = 4'h9;
  localparam logic [IR_W-1:0] OP_BYPASS  = 4'hf;

  // Signature default value is arbitrary
  localparam logic [SIG_W-1:0] SIG_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } csp_scan_t;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } csp_tap_t;
endpackage : csp_pkg

// ==== logic/csp_top.sv ====
/*
  Boundary-scan configuration port, security bit, user signature and
  power-up reset of a small programmable logic device, with its bank of
  macrocell registers. Assumes the scan pins and the device clock pin are
  asynchronous to REF_CLK and much slower than it.
*/
`timescale 1ns/1ps
module csp_top #(
  parameter int N_MC  = 10,             // Registered macrocells
  parameter int DEPTH = 8               // Configuration words
) (
  input  wire logic                       REF_CLK,   // 200 MHz clock
  input  wire logic                       ARST_N,    // Async reset, low
  input  wire logic                       CE,        // Clock enable
  input  wire csp_pkg::csp_scan_t         SCAN,      // Scan port pins
  output logic                            TDO,       // Scan data out
  output logic                            TDO_OE,    // TDO drive enable
  input  wire logic                       USER_CLK,  // Device clock pin
  input  wire logic [N_MC-1:0]            USER_D,    // Macrocell D inputs
  output logic      [N_MC-1:0]            USER_Q,    // Registered pins
  output logic                            USER_OE,   // Pin drive enable
  output logic                            PULLUP_EN, // Input pull-ups on
  output logic                            POR_DONE,  // Reset interval over
  output logic                            SECURED    // Security bit
);
  import csp_pkg::*;

  localparam int AW = $clog2(DEPTH);

  // ------------------------------------------------------------------
  // Reset release and input synchronisers
  // ------------------------------------------------------------------
  logic              rst_s1_r, rst_n_r;
  csp_scan_t         scan_s1_r, scan_s2_r;
  logic              tck_d_r;
  logic              uclk_s1_r, uclk_s2_r, uclk_d_r;
  logic [N_MC-1:0]   ud_s1_r, ud_s2_r;

  // Reset leaves through two flops so release is synchronous
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else if (CE) begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // Pins cross in through two flops; edges are found past the second
  always_ff @(posedge REF_CLK or negedge rst_n_r)
  begin
    if (!rst_n_r) begin
      scan_s1_r <= '0;
      scan_s2_r <= '0;
      tck_d_r   <= 1'b0;
      uclk_s1_r <= 1'b0;
      uclk_s2_r <= 1'b0;
      uclk_d_r  <= 1'b0;
      ud_s1_r   <= '0;
      ud_s2_r   <= '0;
    end else if (CE) begin
      scan_s1_r <= SCAN;
      scan_s2_r <= scan_s1_r;
      tck_d_r   <= scan_s2_r.tck;
      uclk_s1_r <= USER_CLK;
      uclk_s2_r <= uclk_s1_r;
      uclk_d_r  <= uclk_s2_r;
      ud_s1_r   <= USER_D;
      ud_s2_r   <= ud_s1_r;
    end
  end

  logic tck_rise, tck_fall, uclk_rise;
  assign tck_rise  = CE & scan_s2_r.tck & ~tck_d_r;
  assign tck_fall  = CE & ~scan_s2_r.tck & tck_d_r;
  // A clock pin that moves during power-up still gives an edge here
  assign uclk_rise = CE & uclk_s2_r & ~uclk_d_r;

  // ------------------------------------------------------------------
  // Power-up reset interval
  // ------------------------------------------------------------------
  logic [POR_CW-1:0] por_cnt_r;
  logic              por_done_r;

  // Counts the reset interval once after release
  always_ff @(posedge REF_CLK or negedge rst_n_r)
  begin
    if (!rst_n_r) begin
      por_cnt_r  <= '0;
      por_done_r <= 1'b0;
    end else if (CE && !por_done_r) begin
      por_cnt_r  <= por_cnt_r + 1'b1;
      por_done_r <= (por_cnt_r == POR_CW'(POR_CYC - 1));
    end
  end

  logic run_n;
  assign run_n = rst_n_r & por_done_r;  // Low holds the scan logic and macrocell registers in reset

  // ------------------------------------------------------------------
  // Test access port controller
  // ------------------------------------------------------------------
  csp_tap_t st_r, st_nxt;
  logic     tms;
  assign tms = scan_s2_r.tms;

  // Standard 16-state walk, one step per scan clock rise
  always_comb
  begin
    case (st_r)
      TLR:     st_nxt = tms ? TLR    : RTI;
      RTI:     st_nxt = tms ? SEL_DR : RTI;
      SEL_DR:  st_nxt = tms ? SEL_IR : CAP_DR;
      CAP_DR:  st_nxt = tms ? EX1_DR : SH_DR;
      SH_DR:   st_nxt = tms ? EX1_DR : SH_DR;
      EX1_DR:  st_nxt = tms ? UPD_DR : PA_DR;
      PA_DR:   st_nxt = tms ? EX2_DR : PA_DR;
      EX2_DR:  st_nxt = tms ? UPD_DR : SH_DR;
      UPD_DR:  st_nxt = tms ? SEL_DR : RTI;
      SEL_IR:  st_nxt = tms ? TLR    : CAP_IR;
      CAP_IR:  st_nxt = tms ? EX1_IR : SH_IR;
      SH_IR:   st_nxt = tms ? EX1_IR : SH_IR;
      EX1_IR:  st_nxt = tms ? UPD_IR : PA_IR;
      PA_IR:   st_nxt = tms ? EX2_IR : PA_IR;
      EX2_IR:  st_nxt = tms ? UPD_IR : SH_IR;
      UPD_IR:  st_nxt = tms ? SEL_DR : RTI;
      default: st_nxt = TLR;
    endcase
  end

  // Held in reset until the power-up interval ends
  always_ff @(posedge REF_CLK or negedge run_n)
  begin
    if (!run_n)
      st_r <= TLR;
    else if (!scan_s2_r.trst_n)
      st_r <= TLR;
    else if (tck_rise)
      st_r <= st_nxt;
  end

  // ------------------------------------------------------------------
  // Instruction register
  // ------------------------------------------------------------------
  logic [IR_W-1:0] ir_sh_r, ir_r;

  always_ff @(posedge REF_CLK or negedge run_n)
  begin
    if (!run_n) begin
      ir_sh_r <= '0;
      ir_r    <= OP_BYPASS;
    end else if (!scan_s2_r.trst_n || (tck_rise && st_r == TLR)) begin
      ir_r    <= OP_BYPASS;
    end else if (tck_rise) begin
      if (st_r == CAP_IR)
        ir_sh_r <= IR_CAPTURE;
      else if (st_r == SH_IR)
        ir_sh_r <= {scan_s2_r.tdi, ir_sh_r[IR_W-1:1]};
      else if (st_r == UPD_IR)
        ir_r    <= ir_sh_r;
    end
  end

  // ------------------------------------------------------------------
  // Nonvolatile contents: array, security bit, signature
  // ------------------------------------------------------------------
  logic [CFG_W-1:0] mem_r [DEPTH] = '{default: '0};
  logic             secure_r      = 1'b0;
  logic [SIG_W-1:0] sig_r         = SIG_RESET;
  logic [AW-1:0]    addr_r;
  logic             vfy_ok_r;
  logic [DR_W-1:0]  dr_r;
  logic             upd_dr, erase_fire, wr_fire;

  assign upd_dr     = tck_rise && st_r == UPD_DR;
  assign erase_fire = upd_dr && ir_r == OP_ERASE;
  assign wr_fire    = upd_dr && ir_r == OP_WRITE && !secure_r;

  // Contents survive reset; only erase clears the bit
  always_ff @(posedge REF_CLK)
  begin
    if (erase_fire)
      secure_r <= 1'b0;
    else if (run_n && upd_dr && ir_r == OP_SECURE)
      secure_r <= 1'b1;
  end

  // Array write or whole-array erase
  always_ff @(posedge REF_CLK)
  begin
    if (run_n && erase_fire) begin
      for (int i = 0; i < DEPTH; i++)
        mem_r[i] <= '0;
    end else if (run_n && wr_fire) begin
      mem_r[addr_r] <= dr_r[CFG_W-1:0];
    end
  end

  // Signature rewrite is not guarded by the security bit
  always_ff @(posedge REF_CLK)
  begin
    if (run_n && upd_dr && ir_r == OP_SIGWR)
      sig_r <= dr_r;
  end

  // Word pointer restarts with each new instruction
  always_ff @(posedge REF_CLK or negedge run_n)
  begin
    if (!run_n) begin
      addr_r   <= '0;
      vfy_ok_r <= 1'b0;
    end else if (tck_rise && st_r == UPD_IR) begin
      addr_r   <= '0;
    end else if (upd_dr && !secure_r &&
                 (ir_r == OP_READ || ir_r == OP_WRITE ||
                  ir_r == OP_VERIFY)) begin
      addr_r   <= addr_r + 1'b1;
      if (ir_r == OP_VERIFY)
        vfy_ok_r <= (dr_r[CFG_W-1:0] == mem_r[addr_r]);
    end
  end

  // ------------------------------------------------------------------
  // Data register path
  // ------------------------------------------------------------------
  logic [5:0] dr_len;

  always_comb
  begin
    case (ir_r)
      OP_USERSIG, OP_SIGWR:        dr_len = 6'd32;
      OP_READ, OP_WRITE, OP_VERIFY: dr_len = 6'd16;
      default:                     dr_len = 6'd1;
    endcase
  end

  // Capture, then shift LSB first with TDI entering at the top
  always_ff @(posedge REF_CLK or negedge run_n)
  begin
    if (!run_n) begin
      dr_r <= '0;
    end else if (tck_rise && st_r == CAP_DR) begin
      case (ir_r)
        OP_USERSIG: dr_r <= sig_r;
        OP_READ:    dr_r <= secure_r ? '0 :
                            DR_W'(mem_r[addr_r]);
        OP_VERIFY:  dr_r <= secure_r ? '0 : DR_W'(vfy_ok_r);
        default:    dr_r <= '0;
      endcase
    end else if (tck_rise && st_r == SH_DR) begin
      dr_r <= (dr_r >> 1) |
              (DR_W'(scan_s2_r.tdi) << (dr_len - 6'd1));
    end
  end

  // TDO moves on the falling scan clock so the far end samples mid-bit
  always_ff @(posedge REF_CLK or negedge run_n)
  begin
    if (!run_n) begin
      TDO    <= 1'b0;
      TDO_OE <= 1'b0;
    end else if (tck_fall) begin
      TDO    <= (st_r == SH_IR) ? ir_sh_r[0] : dr_r[0];
      TDO_OE <= (st_r == SH_IR) || (st_r == SH_DR);
    end
  end

  // ------------------------------------------------------------------
  // Macrocell registers and pins
  // ------------------------------------------------------------------
  logic [N_MC-1:0] mc_q_r, pol;
  assign pol = mem_r[0][N_MC-1:0];

  // Cleared at power-up; device clock ignored until then
  always_ff @(posedge REF_CLK or negedge run_n)
  begin
    if (!run_n)
      mc_q_r <= '0;
    else if (uclk_rise)
      mc_q_r <= ud_s2_r;
  end

  // Pin level is register through polarity, one cycle behind
  always_ff @(posedge REF_CLK or negedge rst_n_r)
  begin
    if (!rst_n_r) begin
      USER_Q  <= '0;
      USER_OE <= 1'b0;
    end else if (CE) begin
      USER_Q  <= mc_q_r ^ pol;
      USER_OE <= por_done_r;
    end
  end

  assign PULLUP_EN = ~por_done_r;
  assign POR_DONE  = por_done_r;
  assign SECURED   = secure_r;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!rst_n_r);

  // Cycles seen since release; judges the interval length on its own
  logic [POR_CW-1:0] por_seen_r;

  always_ff @(posedge REF_CLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
      por_seen_r <= '0;
    else if (CE && !por_done_r)
      por_seen_r <= por_seen_r + 1'b1;
  end

  chk_read_refused: assert property (
    tck_rise && st_r == CAP_DR && ir_r == OP_READ && secure_r
    |=> dr_r == '0) else $error("readback not refused while secured");
  chk_write_blocked: assert property (
    upd_dr && ir_r == OP_WRITE && secure_r && !erase_fire
    |=> mem_r[$past(addr_r)] == $past(mem_r[addr_r]))
    else $error("array written while secured");
  chk_secure_clear: assert property (
    $fell(secure_r) |-> $past(erase_fire))
    else $error("security bit cleared without erase");
  chk_por_clear: assert property (
    !por_done_r |-> mc_q_r == '0 && st_r == TLR)
    else $error("registers not held during power-up");
  chk_por_length: assert property (
    $rose(por_done_r) |-> por_seen_r == POR_CW'(POR_CYC))
    else $error("power-up interval has wrong length");
  chk_pin_polarity: assert property (
    CE && por_done_r |=> USER_Q == $past(mc_q_r ^ pol))
    else $error("pin not register through polarity");
  chk_pullup_hold: assert property (
    !por_done_r |-> PULLUP_EN && !USER_OE)
    else $error("pull-up dropped before power-up end");
  chk_sig_readable: assert property (
    tck_rise && st_r == CAP_DR && ir_r == OP_USERSIG
    |=> dr_r == $past(sig_r)) else $error("signature not captured");
  chk_clock_ignored: assert property (
    !por_done_r && uclk_rise |=> mc_q_r == '0)
    else $error("device clock acted during power-up");
  chk_ir_capture: assert property (
    tck_rise && st_r == CAP_IR |=> ir_sh_r == IR_CAPTURE)
    else $error("instruction capture pattern wrong");

  cov_secure_set:  cover property ($rose(secure_r));
  cov_erase:       cover property (erase_fire && secure_r);
  cov_read_open:   cover property (upd_dr && ir_r == OP_READ && !secure_r);
  cov_por_release: cover property ($rose(por_done_r));
endmodule : csp_top

// ==== test/csp_prog.sv ====
/*
  Programmer model driving the boundary-scan pins of the device.
  Assumes clk is the 200 MHz reference and one task runs at a time.
*/
`timescale 1ns/1ps
module csp_prog (
  input  wire logic         clk,  // Reference clock
  input  wire logic         tdo,  // Scan data from device
  output csp_pkg::csp_scan_t scan // Scan pins
);
  import csp_pkg::*;

  initial scan = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b1};

  // ------------------------------------------------------------
  // One 80 ns tck period; tck stands low between frames
  // ------------------------------------------------------------
  task automatic tick(input logic ms, input logic di, output logic dout);
    scan.tms = ms;
    scan.tdi = di;
    repeat (8) @(posedge clk);
    #1;
    dout = tdo;      // Taken just before the rising tck
    scan.tck = 1'b1;
    repeat (8) @(posedge clk);
    #1 scan.tck = 1'b0;
  endtask : tick

  // State moves; tdi shows a stale complement, not the last bit
  task automatic walk(input logic [7:0] seq, input int n);
    logic d;
    for (int i = 0; i < n; i++)
      tick(seq[i], ~scan.tdi, d);
  endtask : walk

  task automatic reset_tap();
    walk(8'h1f, 6);
  endtask : reset_tap

  // Test reset pin pulse, then one tick into Run-Test/Idle
  task automatic hard_reset();
    logic d;
    scan.trst_n = 1'b0;
    repeat (8) @(posedge clk);
    #1 scan.trst_n = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    tick(1'b0, 1'b0, d);
  endtask : hard_reset

  // Shift LSB first, then Update and back to Run-Test/Idle
  task automatic shift(input int n, input logic [31:0] din,
                       output logic [31:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++)
      tick(i == n - 1, din[i], dout[i]);
    walk(8'h01, 2);
  endtask : shift

  task automatic load_ir(input logic [IR_W-1:0] code,
                         output logic [IR_W-1:0] capt);
    logic [31:0] q;
    walk(8'h03, 4);
    shift(IR_W, 32'(code), q);
    capt = q[IR_W-1:0];
  endtask : load_ir

  task automatic dr(input int n, input logic [31:0] din,
                    output logic [31:0] dout);
    walk(8'h01, 3);
    shift(n, din, dout);
  endtask : dr
endmodule : csp_prog

// ==== test/testbench.sv ====
/*
  Self-checking bench for the configuration, security and power-up
  block. Assumes the programmer model csp_prog on the scan port.
*/
`timescale 1ns/1ps
module testbench;
  import csp_pkg::*;
  logic ref_clk, arst_n, ce, tdo, tdo_oe, user_clk;
  logic user_oe, pullup_en, por_done, secured;
  logic [9:0]      user_d, user_q;
  csp_scan_t       scan;
  logic [31:0]     q;
  logic [IR_W-1:0] capt;
  int              num_errors, check_count, n;

  csp_top #(.N_MC(10), .DEPTH(8)) dut (
    .REF_CLK(ref_clk), .ARST_N(arst_n), .CE(ce), .SCAN(scan),
    .TDO(tdo), .TDO_OE(tdo_oe), .USER_CLK(user_clk),
    .USER_D(user_d), .USER_Q(user_q), .USER_OE(user_oe),
    .PULLUP_EN(pullup_en), .POR_DONE(por_done), .SECURED(secured));
  // Released TDO floats to its board pull-up, so a late enable shows
  csp_prog prog (.clk(ref_clk), .tdo(tdo_oe ? tdo : 1'b1), .scan(scan));

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
      num_errors++;
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : cyc

  // Reset and wait for the interval; wiggle toggles the clock pin early
  task automatic power_up(input logic wiggle, output int k);
    arst_n = 1'b0;
    cyc(5);
    arst_n = 1'b1;
    k = 0;
    while (por_done !== 1'b1)
    begin
      user_clk = wiggle && k < 100 && k[3];
      cyc(1);
      k++;
      if (k == 50)
      begin
        check("pullup early", pullup_en, 1);
        check("oe early", user_oe, 0);
      end
      if (k > 1000)
      begin
        check("por wait", 0, 1);
        conclude();
      end
    end
    user_clk = 1'b0;
    cyc(4);  // Synchroniser settle before clocking
  endtask : power_up

  task automatic pulse(input logic [9:0] d);
    user_d = d;
    cyc(4);
    user_clk = 1'b1;
    cyc(8);
    user_clk = 1'b0;
    cyc(8);
  endtask : pulse

  task automatic verify_bit(input logic [31:0] exp);
    prog.load_ir(OP_VERIFY, capt);
    prog.dr(CFG_W, 32'h0155, q);
    prog.dr(CFG_W, 32'h0, q);
    check("verify result", 32'(q[0]), exp);
  endtask : verify_bit

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_power();
    user_d = 10'h3ff;  // Clock edges during reset must be ignored
    power_up(1'b1, n);
    check("por cycles ok", 32'(n >= POR_CYC && n <= POR_CYC + 8), 1);
    check("pins cleared", 32'(user_q), 0);
    check("oe after por", user_oe, 1);
    check("pullup after por", pullup_en, 0);
    $display("test power done");
  endtask : t_power

  task automatic t_program();
    prog.reset_tap();
    prog.load_ir(OP_WRITE, capt);
    check("ir capture", 32'(capt), 32'(IR_CAPTURE));
    prog.dr(CFG_W, 32'h0155, q);
    prog.dr(CFG_W, 32'ha5c3, q);
    prog.load_ir(OP_READ, capt);
    prog.dr(CFG_W, 32'h0, q);
    check("word 0", q, 32'h0155);
    prog.dr(CFG_W, 32'h0, q);
    check("word 1", q, 32'ha5c3);
    check("pins polarity", 32'(user_q), 32'h155);
    pulse(10'h3ff);
    check("pins loaded", 32'(user_q), 32'h2aa);
    verify_bit(1);
    $display("test program done");
  endtask : t_program

  task automatic t_secure();
    prog.load_ir(OP_SIGWR, capt);
    prog.dr(SIG_W, 32'h3c5a9617, q);
    prog.load_ir(OP_SECURE, capt);
    prog.dr(1, 32'h0, q);
    check("secured", secured, 1);
    prog.load_ir(OP_READ, capt);
    prog.dr(CFG_W, 32'h0, q);
    check("secured readback", q, 0);
    prog.load_ir(OP_WRITE, capt);
    prog.dr(CFG_W, 32'h00ff, q);
    cyc(4);
    check("pins after blocked write", 32'(user_q), 32'h2aa);
    verify_bit(0);
    prog.load_ir(OP_USERSIG, capt);
    prog.dr(SIG_W, 32'h0, q);
    check("signature", q, 32'h3c5a9617);
    $display("test secure done");
  endtask : t_secure

  task automatic t_reset_erase();
    power_up(1'b0, n);  // Clock pin static here
    check("pins after reset", 32'(user_q), 32'h155);
    check("secured kept", secured, 1);
    prog.load_ir(OP_USERSIG, capt);
    prog.hard_reset();
    prog.dr(SIG_W, 32'h0, q);
    check("bypass after tap reset", q, 0);
    prog.reset_tap();
    prog.load_ir(OP_ERASE, capt);
    prog.dr(1, 32'h0, q);
    check("secured erased", secured, 0);
    prog.load_ir(OP_READ, capt);
    prog.dr(CFG_W, 32'h0, q);
    check("erased word", q, 0);
    $display("test reset and erase done");
  endtask : t_reset_erase

  initial
  begin
    num_errors = 0;
    check_count = 0;
    arst_n = 1'b0;
    ce = 1'b1;
    user_clk = 1'b0;
    user_d = '0;
    t_power();
    t_program();
    t_secure();
    t_reset_erase();
    conclude();
  end
endmodule : testbench
